//--- hw/clock_status_interrupt_unit.sv
// How it works
// - enabled synth lock-loss sticky event pulls irq_out_low low
// - enabled vcxo lock-loss sticky event pulls irq_out_low low
// - per-input loss enable; enabled input loss latch pulls irq_out_low low
// - enabled reference latch interrupts on any change, both directions
// - enabled holdover latch entry pulls irq_out_low low
// - enables reset to zero; disabled latches still record, no interrupt
// - synth sticky reads 0 after any loss since clear, else 1
// - writing 1 clears synth sticky and its pending interrupt
// - vcxo sticky reads 0 after any loss since clear, else 1
// - writing 1 clears vcxo sticky and its pending interrupt
// - each input sticky reads 0 after a loss since clear, else 1
// - writing 1 clears input sticky and its pending interrupt
// - two-bit field shows selected input: 00 input 0, 01 input 1
// - live vcxo lock bit reads 0 during loss; synth live bit is not readable; both feed own sticky latches
// - live input bits read 1 while active, 0 during loss
// - reference sticky records loss; writing 1 clears it, but that change re-raises the interrupt until a second write
// - holdover sticky reads 0 after entry; writing 1 clears it
`timescale 1ns/1ps
module clock_status_interrupt_unit
  import clk_status_pkg::*;
(
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_W-1:0]     paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // status sources, active low where named so
  input  wire logic                  synth_lock_live,
  input  wire logic                  vcxo_lock_live,
  input  wire logic [NUM_INPUTS-1:0] input_active_live,
  input  wire logic [1:0]            selected_input_field,
  input  wire logic                  refstat_live,
  input  wire logic                  holdover_live,
  // interrupt pin
  output logic                       irq_out_low
);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic       acc;
  logic       wr;
  logic       hit;
  logic       in_page;
  logic [7:0] idx;
  logic       wb0;
  logic       sel_en_pll;
  logic       sel_en_ref;
  logic       sel_stk_pll;
  logic       sel_live_pll;
  logic       sel_stk_ref;
  logic       sel_live_ref;

  assign acc     = psel & penable;
  assign wr      = acc & pwrite;
  // word index is the low byte of the word address; the rest must be zero
  assign idx     = paddr[9:2];
  assign in_page = (paddr[ADDR_W-1:10] == '0) && (paddr[1:0] == 2'b00);
  assign wb0     = wr & pstrb[0] & hit;
  assign pready  = 1'b1;

  // one select per register; refused addresses select nothing
  assign sel_en_pll   = in_page && (idx == IDX_PLL_CLOCK_IRQ_ENABLE);
  assign sel_en_ref   = in_page && (idx == IDX_REF_HOLDOVER_IRQ_ENABLE);
  assign sel_stk_pll  = in_page && (idx == IDX_PLL_CLOCK_STICKY_STATUS);
  assign sel_live_pll = in_page && (idx == IDX_PLL_CLOCK_LIVE_STATUS);
  assign sel_stk_ref  = in_page && (idx == IDX_REF_HOLDOVER_STICKY);
  assign sel_live_ref = in_page && (idx == IDX_REF_HOLDOVER_LIVE);
  assign hit          = sel_en_pll | sel_en_ref | sel_stk_pll |
                        sel_live_pll | sel_stk_ref | sel_live_ref;
  assign pslverr      = acc & ~hit;

  // ----------------------------------------------------------------
  // interrupt enables
  // ----------------------------------------------------------------
  logic                  synth_lock_loss_irq_en;
  logic                  vcxo_lock_loss_irq_en;
  logic [NUM_INPUTS-1:0] input_loss_irq_en;
  logic                  refstat_irq_en;
  logic                  holdover_irq_en;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      synth_lock_loss_irq_en <= RST_IRQ_ENABLE[BIT_SYNTH];
      vcxo_lock_loss_irq_en  <= RST_IRQ_ENABLE[BIT_VCXO];
      input_loss_irq_en      <= RST_IRQ_ENABLE[BIT_INPUT0 +: NUM_INPUTS];
    end else if (wb0 && sel_en_pll) begin
      synth_lock_loss_irq_en <= pwdata[BIT_SYNTH];
      vcxo_lock_loss_irq_en  <= pwdata[BIT_VCXO];
      input_loss_irq_en      <= pwdata[BIT_INPUT0 +: NUM_INPUTS];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      refstat_irq_en  <= RST_IRQ_ENABLE[BIT_REF];
      holdover_irq_en <= RST_IRQ_ENABLE[BIT_HOLD];
    end else if (wb0 && sel_en_ref) begin
      refstat_irq_en  <= pwdata[BIT_REF];
      holdover_irq_en <= pwdata[BIT_HOLD];
    end
  end

  // ----------------------------------------------------------------
  // sticky latches (1 = no event), set wins over clear
  // ----------------------------------------------------------------
  logic                  clr_pll;
  logic                  clr_ref;
  logic                  clr_synth;
  logic                  clr_vcxo;
  logic [NUM_INPUTS-1:0] clr_input;
  logic                  clr_refstat;
  logic                  clr_hold;
  logic                  synth_loss;
  logic                  vcxo_loss;
  logic [NUM_INPUTS-1:0] input_loss;
  logic                  ref_loss;
  logic                  hold_entry;
  logic                  synth_lock_sticky;
  logic                  vcxo_lock_sticky;
  logic [NUM_INPUTS-1:0] input_loss_sticky;
  logic                  refstat_sticky;
  logic                  holdover_sticky;
  logic                  refstat_pend;
  logic                  refstat_prev;

  // ----------------------------------------------------------------
  // loss events
  // ----------------------------------------------------------------
  // a live bit low at an edge is an event at that edge
  assign synth_loss = ~synth_lock_live;
  assign vcxo_loss  = ~vcxo_lock_live;
  assign input_loss = ~input_active_live;
  assign ref_loss   = ~refstat_live;
  assign hold_entry = ~holdover_live;

  // ----------------------------------------------------------------
  // write-one-to-clear strobes
  // ----------------------------------------------------------------
  assign clr_pll     = wb0 && sel_stk_pll;
  assign clr_ref     = wb0 && sel_stk_ref;
  assign clr_synth   = clr_pll && pwdata[BIT_SYNTH];
  assign clr_vcxo    = clr_pll && pwdata[BIT_VCXO];
  assign clr_input   = {NUM_INPUTS{clr_pll}} & pwdata[BIT_INPUT0 +: NUM_INPUTS];
  assign clr_refstat = clr_ref && pwdata[BIT_REF];
  assign clr_hold    = clr_ref && pwdata[BIT_HOLD];

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      synth_lock_sticky <= RST_STICKY;
    end else if (synth_loss) begin
      synth_lock_sticky <= 1'b0;
    end else if (clr_synth) begin
      synth_lock_sticky <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      vcxo_lock_sticky <= RST_STICKY;
    end else if (vcxo_loss) begin
      vcxo_lock_sticky <= 1'b0;
    end else if (clr_vcxo) begin
      vcxo_lock_sticky <= 1'b1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_in
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          input_loss_sticky[gi] <= RST_STICKY;
        end else if (input_loss[gi]) begin
          input_loss_sticky[gi] <= 1'b0;
        end else if (clr_input[gi]) begin
          input_loss_sticky[gi] <= 1'b1;
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      refstat_sticky <= RST_STICKY;
    end else if (ref_loss) begin
      refstat_sticky <= 1'b0;
    end else if (clr_refstat) begin
      refstat_sticky <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // reference change detect
  // ----------------------------------------------------------------
  // previous latch value, to see a change in either direction
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      refstat_prev <= RST_STICKY;
    end else begin
      refstat_prev <= refstat_sticky;
    end
  end

  // any change of the reference latch raises a pending flag
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      refstat_pend <= 1'b0;
    end else if (refstat_prev != refstat_sticky) begin
      refstat_pend <= 1'b1;
    end else if (clr_refstat) begin
      refstat_pend <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      holdover_sticky <= RST_STICKY;
    end else if (hold_entry) begin
      holdover_sticky <= 1'b0;
    end else if (clr_hold) begin
      holdover_sticky <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // interrupt output
  // ----------------------------------------------------------------
  localparam int NUM_SRC = NUM_INPUTS + 4;

  logic [NUM_SRC-1:0] src_pend;
  logic               irq_any;

  // masked sources, one pending bit each
  assign src_pend[0]               = synth_lock_loss_irq_en & ~synth_lock_sticky;
  assign src_pend[1]               = vcxo_lock_loss_irq_en & ~vcxo_lock_sticky;
  assign src_pend[2 +: NUM_INPUTS] = input_loss_irq_en & ~input_loss_sticky;
  // reference source is the change flag, not the latch level
  assign src_pend[NUM_INPUTS+2]    = refstat_irq_en & refstat_pend;
  assign src_pend[NUM_INPUTS+3]    = holdover_irq_en & ~holdover_sticky;
  assign irq_any                   = |src_pend;

  // ----------------------------------------------------------------
  // interrupt pin register
  // ----------------------------------------------------------------
  // low while any enabled event pending
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_out_low <= 1'b1;
    end else begin
      irq_out_low <= ~irq_any;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [7:0] word_en_pll;
  logic [7:0] word_en_ref;
  logic [7:0] word_stk_pll;
  logic [7:0] word_live_pll;
  logic [7:0] word_stk_ref;
  logic [7:0] word_live_ref;
  logic [7:0] rd_next;
  logic [7:0] rd_reg;
  logic       rd_setup;

  // register images; reserved bits read zero
  always_comb begin
    word_en_pll                             = 8'h00;
    word_en_pll[BIT_SYNTH]                  = synth_lock_loss_irq_en;
    word_en_pll[BIT_VCXO]                   = vcxo_lock_loss_irq_en;
    word_en_pll[BIT_INPUT0 +: NUM_INPUTS]   = input_loss_irq_en;
    word_en_ref                             = 8'h00;
    word_en_ref[BIT_REF]                    = refstat_irq_en;
    word_en_ref[BIT_HOLD]                   = holdover_irq_en;
    word_stk_pll                            = 8'h00;
    word_stk_pll[BIT_SYNTH]                 = synth_lock_sticky;
    word_stk_pll[BIT_VCXO]                  = vcxo_lock_sticky;
    word_stk_pll[BIT_INPUT0 +: NUM_INPUTS]  = input_loss_sticky;
    word_live_pll                           = 8'h00;
    word_live_pll[BIT_SEL_LO +: 2]          = selected_input_field;
    word_live_pll[BIT_VCXO]                 = vcxo_lock_live;
    word_live_pll[BIT_INPUT0 +: NUM_INPUTS] = input_active_live;
    word_stk_ref                            = 8'h00;
    word_stk_ref[BIT_REF]                   = refstat_sticky;
    word_stk_ref[BIT_HOLD]                  = holdover_sticky;
    word_live_ref                           = 8'h00;
    word_live_ref[BIT_REF]                  = refstat_live;
    word_live_ref[BIT_HOLD]                 = holdover_live;
  end

  // selects are one-hot; refused addresses read zero
  assign rd_next = ({8{sel_en_pll}}   & word_en_pll)   |
                   ({8{sel_en_ref}}   & word_en_ref)   |
                   ({8{sel_stk_pll}}  & word_stk_pll)  |
                   ({8{sel_live_pll}} & word_live_pll) |
                   ({8{sel_stk_ref}}  & word_stk_ref)  |
                   ({8{sel_live_ref}} & word_live_ref);

  // ----------------------------------------------------------------
  // read capture
  // ----------------------------------------------------------------
  // taken in the setup cycle so the word stands through the access phase
  assign rd_setup = psel & ~penable & ~pwrite;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rd_reg <= 8'h00;
    end else if (rd_setup) begin
      rd_reg <= rd_next;
    end
  end

  assign prdata = {24'h000000, rd_reg};

endmodule

//--- hw/clk_status_pkg.sv
package clk_status_pkg;

  // ----------------------------------------------------------------
  // register offsets (printed offsets not all multiples of four: index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_PLL_CLOCK_IRQ_ENABLE     = 8'h68;
  localparam logic [7:0] IDX_REF_HOLDOVER_IRQ_ENABLE  = 8'h69;
  localparam logic [7:0] IDX_PLL_CLOCK_STICKY_STATUS  = 8'h6c;
  localparam logic [7:0] IDX_PLL_CLOCK_LIVE_STATUS    = 8'h6d;
  localparam logic [7:0] IDX_REF_HOLDOVER_STICKY      = 8'h6e;
  localparam logic [7:0] IDX_REF_HOLDOVER_LIVE        = 8'h6f;
  localparam int         ADDR_W                       = 12;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_INPUT0  = 0;
  localparam int BIT_VCXO    = 4;
  localparam int BIT_SYNTH   = 5;
  localparam int BIT_SEL_LO  = 5;
  localparam int BIT_HOLD    = 0;
  localparam int BIT_REF     = 1;
  localparam int NUM_INPUTS  = 2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
  localparam logic       RST_STICKY     = 1'b1;

endpackage

//--- sim/clock_status_interrupt_unit_chk.sv
`timescale 1ns/1ps
module clock_status_interrupt_unit_chk
  import clk_status_pkg::*;
(
  // bus
  input wire logic                  sys_clk,
  input wire logic                  rst_n,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [ADDR_W-1:0]     paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  // status
  input wire logic                  synth_lock_live,
  input wire logic                  vcxo_lock_live,
  input wire logic [NUM_INPUTS-1:0] input_active_live,
  input wire logic [1:0]            selected_input_field,
  input wire logic                  irq_out_low
);
  localparam logic [11:0] A_EN   = {2'h0, IDX_PLL_CLOCK_IRQ_ENABLE, 2'h0};
  localparam logic [11:0] A_STK  = {2'h0, IDX_PLL_CLOCK_STICKY_STATUS, 2'h0};
  localparam logic [11:0] A_LIVE = {2'h0, IDX_PLL_CLOCK_LIVE_STATUS, 2'h0};
  logic acc;
  logic wr;
  logic en_reg;
  assign acc = psel && penable;
  assign wr  = acc && pwrite;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // copy of the synth enable, updated at the same edge as the block's
  always_ff @(posedge sys_clk) begin
    if (!rst_n) en_reg <= 1'b0;
    else if (wr && paddr == A_EN) en_reg <= pwdata[BIT_SYNTH];
  end
  sequence rd_at(logic [11:0] a);
    acc && !pwrite && paddr == a;
  endsequence
  sequence lock_lost;
    en_reg && !synth_lock_live ##1 en_reg;
  endsequence
  a_reset_irq_idle: assert property ($rose(rst_n) |-> irq_out_low)
    else $error("irq active after reset");
  a_ready_no_wait: assert property (acc |-> pready)
    else $error("pready low in access");
  a_err_bad_addr: assert property (acc && paddr[11:8] != 4'h1 |-> pslverr)
    else $error("no pslverr for unmapped address");
  a_sel_field: assert property (rd_at(A_LIVE) |-> prdata[6:5] == $past(selected_input_field))
    else $error("selection field wrong");
  a_live_bits: assert property (rd_at(A_LIVE) |-> prdata[4] == $past(vcxo_lock_live)
    && prdata[1:0] == $past(input_active_live)) else $error("live bits wrong");
  a_synth_sticky: assert property ($past(rst_n, 2) && !$past(synth_lock_live, 2)
    ##0 rd_at(A_STK) |-> !prdata[5]) else $error("synth sticky missed event");
  a_other_sticky: assert property ($past(rst_n, 2) ##0 rd_at(A_STK)
    |-> (!prdata[4] || $past(vcxo_lock_live, 2))
    && (prdata[1:0] & ~$past(input_active_live, 2)) == 2'h0)
    else $error("sticky missed event");
  a_irq_follows: assert property (lock_lost |=> !irq_out_low)
    else $error("irq not raised by synth event");
  a_irq_release: assert property ($rose(irq_out_low) |-> $past(wr) || $past(wr, 2))
    else $error("irq released without a write");
endmodule
bind clock_status_interrupt_unit clock_status_interrupt_unit_chk chk_i (
  .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .synth_lock_live(synth_lock_live), .vcxo_lock_live(vcxo_lock_live),
  .input_active_live(input_active_live), .selected_input_field(selected_input_field),
  .irq_out_low(irq_out_low));

//--- sim/status_source_model.sv
`timescale 1ns/1ps
module status_source_model (
  // bench command, one bit a source
  input  wire logic       sys_clk,
  input  wire logic [5:0] drop,
  // status lines, 1 = healthy
  output logic      [5:0] healthy,
  output logic      [1:0] sel
);
  initial healthy = 6'h3f;
  initial sel = 2'h0;
  // selection moves away from an input that lost its signal
  always @(posedge sys_clk) begin
    healthy <= ~drop;
    if (drop[0]) sel <= 2'h1;
    else if (drop[1]) sel <= 2'h0;
  end
endmodule

//--- sim/clock_status_interrupt_unit_test.sv
`timescale 1ns/1ps
module clock_status_interrupt_unit_test import clk_status_pkg::*; ();
  localparam logic [11:0] EN   = {2'h0, IDX_PLL_CLOCK_IRQ_ENABLE, 2'h0};
  localparam logic [11:0] EN2  = {2'h0, IDX_REF_HOLDOVER_IRQ_ENABLE, 2'h0};
  localparam logic [11:0] STK  = {2'h0, IDX_PLL_CLOCK_STICKY_STATUS, 2'h0};
  localparam logic [11:0] STK2 = {2'h0, IDX_REF_HOLDOVER_STICKY, 2'h0};
  localparam logic [11:0] LIVE = {2'h0, IDX_PLL_CLOCK_LIVE_STATUS, 2'h0};
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [5:0]  drop = 6'h0;
  logic [5:0]  healthy;
  logic [1:0]  sel;
  logic [31:0] rd;
  logic        err;
  logic [31:0] seed;
  logic [7:0]  m;
  logic [11:0] a_en;
  logic [11:0] a_st;
  logic [7:0]  bm [6] = '{8'h01, 8'h02, 8'h10, 8'h20, 8'h01, 8'h02};
  int          num_errors = 0;
  int          check_count = 0;
  always #5 sys_clk = ~sys_clk;
  status_source_model src (.sys_clk(sys_clk), .drop(drop), .healthy(healthy), .sel(sel));
  clock_status_interrupt_unit uut (
    .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .synth_lock_live(healthy[3]), .vcxo_lock_live(healthy[2]),
    .input_active_live(healthy[1:0]), .selected_input_field(sel),
    .refstat_live(healthy[5]), .holdover_live(healthy[4]), .irq_out_low(irq));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [7:0] spread(input logic [3:0] s);
    return {2'h0, s[3:2], 2'h0, s[1:0]};
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("Error t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  // one-cycle loss on the chosen sources, then time for the latch to land
  task automatic pulse(input logic [5:0] s);
    drop <= s;
    @(posedge sys_clk);
    drop <= 6'h0;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic wrap_up();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge sys_clk);
    num_errors++;
    wrap_up();
  end
  initial begin
    seed = 32'd73907;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    apb(EN, 1'b0, 8'h0);
    chk(rd, 32'h0);
    apb(EN2, 1'b0, 8'h0);
    chk(rd, 32'h0);
    apb(STK, 1'b0, 8'h0);
    chk(rd & 32'h33, 32'h33);
    apb(12'h0a8, 1'b1, 8'hff);
    chk(err, 1'b1);
    for (int k = 0; k < 6; k++) begin
      a_en = (k < 4) ? EN : EN2;
      a_st = (k < 4) ? STK : STK2;
      pulse(6'(1 << k));
      apb(a_st, 1'b0, 8'h0);
      chk(rd & bm[k], 32'h0);
      chk(irq, 1'b1);
      apb(a_en, 1'b1, bm[k]);
      repeat (2) @(posedge sys_clk);
      chk(irq, 1'b0);
      apb(a_st, 1'b1, bm[k]);
      if (k == 5) begin
        repeat (2) @(posedge sys_clk);
        chk(irq, 1'b0);
        apb(a_st, 1'b1, bm[k]);
      end
      repeat (2) @(posedge sys_clk);
      chk(irq, 1'b1);
      apb(a_st, 1'b0, 8'h0);
      chk(rd & bm[k], bm[k]);
      apb(a_en, 1'b1, 8'h0);
    end
    apb(EN, 1'b1, 8'h33);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      m = spread(seed[3:0]);
      pulse({2'h0, seed[3:0]});
      apb(LIVE, 1'b0, 8'h0);
      chk(rd & 32'h13, 32'h13);
      apb(STK, 1'b0, 8'h0);
      chk(rd & 32'h33, {24'h0, ~m & 8'h33});
      seed = lfsr(seed);
      apb(STK, 1'b1, seed[7:0]);
      repeat (2) @(posedge sys_clk);
      chk(irq, ~|(m & ~seed[7:0]));
      apb(STK, 1'b1, 8'h33);
    end
    wrap_up();
  end
endmodule
